// >>> verilog/rcs_consts.vh
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH
// apb register offsets
`define RCS_ADDR_CFG0     8'h00
`define RCS_ADDR_CFG1     8'h04
`define RCS_ADDR_EXT      8'h08
`define RCS_ADDR_STAT     8'h0C
// configuration field positions
`define RCS_BIT_HLD       4
`define RCS_BIT_PRE       5
`define RCS_TT_LO         6
`define RCS_TT_HI         7
`define RCS_CFG_RST       8'h00
// threshold codes and word counts
`define RCS_TT_SMALL      2'h0
`define RCS_TT_MID        2'h2
`define RCS_TT_LARGE      2'h3
`define RCS_THR_8         10'h008
`define RCS_THR_128       10'h080
`define RCS_THR_256       10'h100
`define RCS_THR_512       10'h200
`define RCS_FIFO_MAX      10'h3FF
`define RCS_LVL_ZERO      10'h000
`define RCS_LVL_ONE       10'h001
`endif

// >>> verilog/rcs_scheduler.v
// How it works
// - with the preempt bit set, the high channel may preempt and the low channel prestages; the high channel prestages unless its request is immediate.
// - with the preempt bit clear, preemption is off and the high channel still prestages.
// - a high request with preemption on purges a low frame still in staging from the fifo, to be fetched again later.
// - a high request during low service with preemption on lets the current frame finish, then releases the token and returns to start.
// - after the high request is served, the low channel resumes with no loss of its data.
// - a prestaging channel loads its next frame into the fifo before the token arrives.
// - without prestaging, staging waits for token capture.
// - after capture, data is fetched and transmission asked for once the fifo reaches the threshold or holds the whole frame.
// - immediate service class requests never prestage.
// - with the preempt bit clear the low channel prestages only when its hold bit is clear, and a clear hold bit forces it.
// - low prestage off, no high request, empty fifo at capture and hold clear release the token at once.
// - the threshold field with the extended bit sets the fifo level needed before transmission is asked for.
// - code 00 selects 8 or 512 words.
// - code 10 selects 128 words or a reserved setting.
// - code 11 selects 256 words or a whole frame in the fifo.
// - a set hold bit keeps the service opportunity open until the request completes.
//
// Chosen here: the APB interface to the registers and the address map.
module rcs_scheduler (
   // clock and reset
   input  wire        mclk,
   input  wire        rst_n,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // request channels, bit 0 high priority, bit 1 low priority
   input  wire [1:0]  req_active,
   input  wire [1:0]  req_immediate,
   // output data units from host memory
   input  wire        odu_valid,
   input  wire        odu_last,
   output reg         odu_ready,
   output reg         odu_chan,
   output reg         purge,
   // ring engine
   input  wire        token_captured,
   input  wire        tx_word_take,
   input  wire        tx_frame_done,
   output reg         tx_request,
   output reg         tx_chan,
   output reg         token_release
);
`include "rcs_consts.vh"

   // one-hot request machine states
   localparam [3:0] ST_START = 4'h1;
   localparam [3:0] ST_STAGE = 4'h2;
   localparam [3:0] ST_SERVE = 4'h4;
   localparam [3:0] ST_DRAIN = 4'h8;

   // configuration storage
   reg  [7:0]  cfg_reg [0:1];
   reg  [1:0]  ext_reg;

   // request machine state
   reg  [3:0]  state_reg;
   reg  [3:0]  state_next;
   reg  [9:0]  level_reg;
   reg  [9:0]  level_next;
   reg         token_reg;
   reg         token_next;
   reg         chan_reg;
   reg         chan_next;
   reg         frame_in_reg;
   reg         frame_in_next;
   reg         commit_reg;
   reg         commit_next;
   reg         preempt_reg;
   reg         preempt_next;

   // next values of the pulse and level outputs
   reg         release_next;
   reg         purge_next;
   reg         fetch_next;
   reg         txreq_next;

   // apb read path
   reg  [31:0] rd_data;
   reg         rd_err;

   // reset loop index
   integer     i;

   // threshold in words; reserved and end-of-frame codes return zero
   function [9:0] thr_words;
      input [1:0] tt;
      input       ext;
      begin
         case (tt)
            `RCS_TT_SMALL: thr_words = ext ? `RCS_THR_512 : `RCS_THR_8;
            `RCS_TT_MID:   thr_words = ext ? `RCS_LVL_ZERO : `RCS_THR_128;
            `RCS_TT_LARGE: thr_words = ext ? `RCS_LVL_ZERO : `RCS_THR_256;
            default:       thr_words = `RCS_LVL_ZERO;
         endcase
      end
   endfunction

   // true when a code means waiting for a whole frame
   function whole_frame;
      input [1:0] tt;
      input       ext;
      begin
         whole_frame = (tt == `RCS_TT_LARGE) & ext;
      end
   endfunction

   // true when the fifo holds no word
   function is_empty;
      input [9:0] lvl;
      begin
         is_empty = (lvl == `RCS_LVL_ZERO);
      end
   endfunction

   // request level of the channel selected by ch
   function chan_req;
      input [1:0] req;
      input       ch;
      begin
         chan_req = ch ? req[1] : req[0];
      end
   endfunction

   // per-channel control decode
   wire       pre_hi   = cfg_reg[0][`RCS_BIT_PRE];
   wire       pre_lo   = cfg_reg[1][`RCS_BIT_PRE];
   wire       hld_lo   = cfg_reg[1][`RCS_BIT_HLD];
   wire       preempt_en = pre_hi;
   wire       stage_hi = ~req_immediate[0];
   // low prestage: preempt bit, or hold bit clear, never immediate
   wire       stage_lo = (pre_lo | ~hld_lo)
                         & ~req_immediate[1];
   // settings of the channel now being served
   wire [7:0] cur_cfg  = cfg_reg[chan_reg];
   wire       cur_hld  = cur_cfg[`RCS_BIT_HLD];
   wire [1:0] cur_tt   = cur_cfg[`RCS_TT_HI:`RCS_TT_LO];
   wire       cur_ext  = ext_reg[chan_reg];
   wire       cur_stage = chan_reg ? stage_lo : stage_hi;
   wire [9:0] cur_thr  = thr_words(cur_tt, cur_ext);
   wire       cur_eof  = whole_frame(cur_tt, cur_ext);
   // code 01 and code 10 extended are reserved: wait for a frame
   wire       cur_rsvd = (cur_thr == `RCS_LVL_ZERO) & ~cur_eof;
   // fifo status and the live request of the current channel
   wire       lvl_empty = is_empty(level_reg);
   wire       cur_req  = chan_req(req_active, chan_reg);
   // handshake strobes toward host and ring
   wire       odu_take = odu_valid & odu_ready;
   wire       wd_take  = tx_word_take & ~lvl_empty;
   // threshold reached, or the whole frame staged for short frames
   wire       thr_met  = (cur_eof | cur_rsvd) ? frame_in_reg
                         : (level_reg >= cur_thr
                            | frame_in_reg);
   // stop fetching at the top of the fifo
   wire       fifo_room = level_reg != `RCS_FIFO_MAX;

   // apb read mux
   always @* begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (paddr)
         `RCS_ADDR_CFG0: rd_data[7:0] = cfg_reg[0];
         `RCS_ADDR_CFG1: rd_data[7:0] = cfg_reg[1];
         `RCS_ADDR_EXT:  rd_data[1:0] = ext_reg;
         `RCS_ADDR_STAT: rd_data = {12'h000, token_reg, chan_reg,
                                    frame_in_reg, commit_reg,
                                    level_reg, 2'h0, state_reg};
         // unmapped offsets answer with an error
         default:        rd_err = 1'b1;
      endcase
   end

   // apb slave: one wait state, then the access completes
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         // configuration comes up cleared
         ext_reg <= 2'h0;
         for (i = 0; i < 2; i = i + 1) begin
            cfg_reg[i] <= `RCS_CFG_RST;
         end
      end else begin
         // pready pulses one cycle after the first access edge
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & rd_err;
         if (psel & penable & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
         end
         // the write lands at the edge that sees pready high;
         // writes to status or unmapped offsets are dropped
         if (psel & penable & pready & pwrite) begin
            case (paddr)
               `RCS_ADDR_CFG0: cfg_reg[0] <= pwdata[7:0];
               `RCS_ADDR_CFG1: cfg_reg[1] <= pwdata[7:0];
               `RCS_ADDR_EXT:  ext_reg    <= pwdata[1:0];
               default:        ext_reg    <= ext_reg;
            endcase
         end
      end
   end

   // request machine
   always @* begin
      state_next    = state_reg;
      chan_next     = chan_reg;
      token_next    = token_reg | token_captured;
      frame_in_next = frame_in_reg | (odu_take & odu_last);
      commit_next   = commit_reg;
      preempt_next  = preempt_reg;
      release_next  = 1'b0;
      purge_next    = 1'b0;
      fetch_next    = 1'b0;
      txreq_next    = 1'b0;
      level_next    = level_reg;
      // level follows words in minus words out
      if (odu_take & ~wd_take) begin
         level_next = level_reg + `RCS_LVL_ONE;
      end else if (wd_take & ~odu_take) begin
         level_next = level_reg - `RCS_LVL_ONE;
      end
      case (state_reg)
         ST_START: begin
            // high channel has priority for the next opportunity
            if (req_active[0]) begin
               chan_next  = 1'b0;
               state_next = ST_STAGE;
            end else if (req_active[1]) begin
               chan_next  = 1'b1;
               state_next = ST_STAGE;
            end else if (token_captured & ~hld_lo & lvl_empty) begin
               // idle with nothing to send: give the token back
               release_next = 1'b1;
               token_next   = 1'b0;
            end
         end
         ST_STAGE: begin
            // prestage before the token, or wait for capture
            fetch_next = (cur_stage | token_next)
                         & ~frame_in_next & fifo_room;
            if (chan_reg & req_active[0] & preempt_en
                & ~commit_reg) begin
               // high channel preempts an uncommitted low frame
               purge_next    = 1'b1;
               level_next    = `RCS_LVL_ZERO;
               frame_in_next = 1'b0;
               fetch_next    = 1'b0;
               chan_next     = 1'b0;
            end else if (token_next) begin
               if (~chan_reg & ~req_active[0] & ~stage_lo & ~hld_lo
                   & lvl_empty) begin
                  // nothing staged: hand the token straight back
                  release_next = 1'b1;
                  token_next   = 1'b0;
                  state_next   = ST_START;
               end else begin
                  state_next = ST_SERVE;
               end
            end
         end
         ST_SERVE: begin
            // fetch under the token, ask to send at threshold;
            // no fetch once the request has gone
            fetch_next  = ~frame_in_next & fifo_room & cur_req;
            txreq_next  = thr_met | commit_reg;
            // commit once the first word leaves above threshold
            commit_next = commit_reg | (thr_met & wd_take);
            // preemption waits for the frame in flight to finish
            if (chan_reg & req_active[0] & preempt_en) begin
               preempt_next = 1'b1;
            end
            // the end of frame clears the fifo count
            if (tx_frame_done) begin
               // no fetch on the closing cycle, the level restarts
               fetch_next    = 1'b0;
               commit_next   = 1'b0;
               frame_in_next = 1'b0;
               txreq_next    = 1'b0;
               level_next    = `RCS_LVL_ZERO;
               // hold keeps the opportunity until the request ends
               if (preempt_reg | preempt_next) begin
                  state_next = ST_DRAIN;
               end else if (cur_hld & cur_req) begin
                  state_next = ST_SERVE;
               end else begin
                  state_next = ST_DRAIN;
               end
            end else if (~cur_req & ~commit_reg & lvl_empty) begin
               // request complete: the opportunity ends, hold or not
               state_next = ST_DRAIN;
            end
         end
         ST_DRAIN: begin
            // give the token back and reprioritise from start
            release_next = 1'b1;
            token_next   = 1'b0;
            preempt_next = 1'b0;
            state_next   = ST_START;
         end
         default: begin
            state_next = ST_START;
         end
      endcase
   end

   // machine and output registers
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg     <= ST_START;
         level_reg     <= `RCS_LVL_ZERO;
         token_reg     <= 1'b0;
         chan_reg      <= 1'b0;
         frame_in_reg  <= 1'b0;
         commit_reg    <= 1'b0;
         preempt_reg   <= 1'b0;
         odu_ready     <= 1'b0;
         odu_chan      <= 1'b0;
         purge         <= 1'b0;
         tx_request    <= 1'b0;
         tx_chan       <= 1'b0;
         token_release <= 1'b0;
      end else begin
         state_reg     <= state_next;
         level_reg     <= level_next;
         token_reg     <= token_next;
         chan_reg      <= chan_next;
         frame_in_reg  <= frame_in_next;
         commit_reg    <= commit_next;
         preempt_reg   <= preempt_next;
         odu_ready     <= fetch_next & ~odu_take;
         odu_chan      <= chan_next;
         purge         <= purge_next;
         tx_request    <= txreq_next;
         tx_chan       <= chan_next;
         // pulse outputs fall again unless the machine asks once more
         token_release <= release_next;
      end
   end

endmodule

// >>> sim/rcs_ring_model.sv
module rcs_ring_model (
   // clock and reset
   input  wire       mclk,
   input  wire       rst_n,
   // request from the scheduler
   input  wire       tx_request,
   input  wire       tx_chan,
   // frame lengths and pace set by the bench
   input  wire [9:0] len_h,
   input  wire [9:0] len_l,
   input  wire       slow,
   // transmit strobes
   output logic      tx_word_take,
   output logic      tx_frame_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int        n;
   int        gap;
   logic      wait_lo;
   wire [9:0] len = tx_chan ? len_l : len_h;
   // one frame per request, then idle until the request drops
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         n <= 0;
         gap <= 0;
         wait_lo <= 1'b0;
         tx_word_take <= 1'b0;
         tx_frame_done <= 1'b0;
      end else begin
         tx_word_take <= 1'b0;
         tx_frame_done <= 1'b0;
         if (!tx_request) begin
            n <= 0;
            wait_lo <= 1'b0;
         end else if (!wait_lo) begin
            if (n == len) begin
               tx_frame_done <= 1'b1;
               wait_lo <= 1'b1;
            end else if (gap != 0) begin
               gap <= gap - 1;
            end else begin
               tx_word_take <= 1'b1;
               n <= n + 1;
               gap <= slow ? 3 : 0; // slow pace lags the host fill
            end
         end
      end
   end
endmodule

// >>> sim/rcs_scheduler_checker.sv
module rcs_scheduler_checker (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // apb
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // fetch side
   input wire odu_valid,
   input wire odu_ready,
   input wire purge,
   // ring side
   input wire tx_request,
   input wire tx_chan,
   input wire tx_frame_done,
   input wire token_release
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // bus answer, fetch pace, pulse widths, request hold and token release after a frame
   apb_answer_a: assert property (psel && !penable |-> ##2 pready)
      else $error("apb answer not on time");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   odu_pace_a: assert property (odu_valid && odu_ready |=> !odu_ready)
      else $error("odu_ready held after a word");
   purge_pulse_a: assert property (purge |=> !purge)
      else $error("purge longer than one cycle");
   release_pulse_a: assert property (token_release |=> !token_release)
      else $error("token_release longer than one cycle");
   tx_hold_a: assert property (tx_request && !tx_frame_done
      |=> tx_request && $stable(tx_chan)) else $error("request dropped");
   drain_rel_a: assert property (tx_request && tx_frame_done
      |-> ##[1:3] token_release) else $error("token not released");
   cover property (purge);
   cover property (token_release && !tx_request);
   cover property (pslverr);
endmodule
bind rcs_scheduler rcs_scheduler_checker i_chk (.mclk, .rst_n, .psel,
   .penable, .pready, .pslverr, .odu_valid, .odu_ready, .purge,
   .tx_request, .tx_chan, .tx_frame_done, .token_release);

// >>> sim/tb_rcs_scheduler.sv
module tb_rcs_scheduler;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic        odu_valid = 0, token_captured = 0, slow = 0, rerr, rch;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, rdat;
   logic [1:0]  req_active = 0, req_immediate = 0;
   wire  [31:0] prdata;
   wire         pready, pslverr, odu_ready, odu_chan, odu_last, purge;
   wire         tx_request, tx_chan, token_release, tx_word_take;
   wire         tx_frame_done;
   int          failures = 0, num_checks = 0, seed = 78204, t, e, r, rc;
   int          cnt[2], lenv[2], codes[7] = '{0, 4, 6, 1, 7, 5, 2};
   int          n_rel = 0, n_pur = 0;
   assign odu_last = cnt[odu_chan] == lenv[odu_chan] - 1;
   rcs_scheduler i_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .req_active, .req_immediate,
      .odu_valid, .odu_last, .odu_ready, .odu_chan, .purge,
      .token_captured, .tx_word_take, .tx_frame_done, .tx_request,
      .tx_chan, .token_release);
   rcs_ring_model i_ring (.mclk, .rst_n, .tx_request, .tx_chan,
      .len_h(lenv[0][9:0]), .len_l(lenv[1][9:0]), .slow, .tx_word_take,
      .tx_frame_done);
   // clock and watchdog
   initial forever #20 mclk = ~mclk;
   initial begin
      #2400000;
      failures++;
      results();
   end
   // host memory: holds each word until taken, rewinds on purge
   always @(posedge mclk) begin
      if (odu_valid && odu_ready) cnt[odu_chan] <= cnt[odu_chan] + 1;
      if (purge) cnt[1] <= 0;
      odu_valid <= (odu_valid && !odu_ready) || ($random(seed) % 4 != 0);
      n_rel <= n_rel + token_release;
      n_pur <= n_pur + purge;
   end
   task cmp(input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         failures++;
         $display("Error at %0t: seen %0h expected %0h", $time, s, x);
      end
   endtask
   task results();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task apb(input bit w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cap();
      repeat (3) @(posedge mclk);
      token_captured <= 1'b1;
      @(posedge mclk);
      token_captured <= 1'b0;
   endtask
   // capture, note fill at the request, wait for the end of the frame
   task frame(input logic [1:0] keep);
      r = n_rel;
      cap();
      while (tx_request !== 1'b1) @(posedge mclk);
      rch = tx_chan;
      rc = cnt[tx_chan];
      while (tx_frame_done !== 1'b1) @(posedge mclk);
      req_active <= keep;
      req_immediate <= 2'b00;
      repeat (8) @(posedge mclk);
      cmp(n_rel - r, 1);
   endtask
   task np(input int ch, input logic i, input logic [7:0] cf, input bit x);
      apb(1'b1, ch ? 8'h04 : 8'h00, {24'h000000, cf});
      cnt = '{0, 0};
      lenv[ch] = 8;
      req_immediate[ch] <= i;
      req_active[ch] <= 1'b1;
      repeat (30) @(posedge mclk);
      cmp(cnt[ch] != 0, x);
      frame(2'b00);
      cmp(rc, 8);
   endtask
   function int thr(input int c);
      case (c)
         0: return 8;
         4: return 128;
         6: return 256;
         1: return 512;
         default: return 0;
      endcase
   endfunction
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 0; a < 20; a += 4) begin
         apb(1'b0, a[7:0], 32'h0);
         cmp(rerr, a == 16);
         cmp(a == 12 ? rdat[3:0] : rdat, a == 12);
      end
      t = $random(seed);
      apb(1'b1, 8'h04, t);
      apb(1'b0, 8'h04, 32'h0);
      cmp(rdat[7:0], t[7:0]);
      apb(1'b1, 8'h08, 32'h3);
      np(1, 0, 8'hD0, 0);
      np(1, 0, 8'hC0, 1);
      np(1, 0, 8'hF0, 1);
      np(0, 1, 8'hC0, 0);
      np(0, 0, 8'hC0, 1);
      apb(1'b1, 8'h04, 32'hC0);
      r = n_rel;
      cap();
      repeat (4) @(posedge mclk);
      cmp(n_rel - r, 1);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 8'h00, codes[i] >> 1 << 6);
         apb(1'b1, 8'h08, codes[i] & 1);
         e = thr(codes[i]) ? thr(codes[i]) : 40;
         lenv[0] = thr(codes[i]) ? e + 20 : e;
         cnt = '{0, 0};
         slow <= thr(codes[i]) != 0;
         req_active <= 2'b01;
         frame(2'b00);
         cmp(rc >= e && rc <= e + 1, 1);
      end
      apb(1'b1, 8'h00, 32'h20);
      apb(1'b1, 8'h04, 32'hB0);
      apb(1'b1, 8'h08, 32'h0);
      lenv = '{10, 300};
      cnt = '{0, 0};
      slow <= 1'b1;
      req_active <= 2'b10;
      repeat (60) @(posedge mclk);
      cmp(cnt[1] > 0, 1);
      req_active <= 2'b11;
      frame(2'b10);
      cmp(n_pur, 1);
      cmp(rch, 0);
      frame(2'b00);
      cmp(rch, 1);
      cmp(cnt[1], 300);
      results();
   end
endmodule
